// ==== hdl/eapm_pin_cell.sv ====
// Purpose: One address pin: function select and pulldown control.
// Assumes: Active-low output enables on both sources.
// Notes: All outputs are registered.

`timescale 1ns/100ps

module eapm_pin_cell (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_mem_sel,
  input wire logic i_gp_out,
  input wire logic i_gp_oe_n,
  input wire logic i_mem_out,
  input wire logic i_mem_oe_n,
  input wire logic i_pull_inhibit,
  output logic o_pin_out,
  output logic o_pin_oe_n,
  output logic o_pulldown_en
);

  // ==========================================================
  // Function mux, memory side only when selected
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin_out <= 1'b0;
      o_pin_oe_n <= 1'b1;
    end else if (i_mem_sel) begin
      o_pin_out <= i_mem_out;
      o_pin_oe_n <= i_mem_oe_n;
    end else begin
      o_pin_out <= i_gp_out;
      o_pin_oe_n <= i_gp_oe_n;
    end
  end

  // Pulldown on when the inhibit bit is clear
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pulldown_en <= 1'b0;
    end else begin
      o_pulldown_en <= ~i_pull_inhibit;
    end
  end

endmodule

// ==== hdl/eapm_top.sv ====
// Purpose: Address pin mux for lines 11..20 with Wishbone registers.
// Assumes: Classic Wishbone, one wait state, 32-bit data.
// Notes: Board wiring of memory address bits is outside this block.
//
// Our own choice: the Wishbone interface to the registers.

`timescale 1ns/100ps

module eapm_top
  import eapm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [EAPM_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [EAPM_DAT_W-1:0] i_wb_dat,
  output logic [EAPM_DAT_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  // Memory interface side
  input wire logic [EAPM_HI_LINE:EAPM_LO_LINE] i_mem_addr,
  input wire logic i_mem_addr_oe_n,
  input wire logic i_nand_active,
  input wire logic i_nand_cle,
  input wire logic i_nand_ale,
  // General I/O side for shared pins
  input wire logic [EAPM_NSHARED-1:0] i_gp_out,
  input wire logic [EAPM_NSHARED-1:0] i_gp_oe_n,
  output logic [EAPM_NSHARED-1:0] o_gp_in,
  // Pads
  input wire logic [EAPM_HI_LINE:EAPM_LO_LINE] i_pad_in,
  output logic [EAPM_HI_LINE:EAPM_LO_LINE] o_pad_out,
  output logic [EAPM_HI_LINE:EAPM_LO_LINE] o_pad_oe_n,
  output logic [EAPM_HI_LINE:EAPM_LO_LINE] o_pad_pulldown_en
);

  // ==========================================================
  // Registers
  logic [EAPM_NSHARED-1:0] bus_select_reg_q;
  logic [EAPM_NSHARED-1:0] pull_inhibit_ctrl_a_q;
  logic [EAPM_PULL_B_W-1:0] pull_inhibit_ctrl_b_q;
  logic [EAPM_NPIN-1:0] pad_meta_q;
  logic [EAPM_NPIN-1:0] pad_sync_q;
  logic [13:0] idx;
  logic wr_go;
  logic rd_go;
  logic [EAPM_HI_LINE:EAPM_LO_LINE] mem_out;
  logic [EAPM_HI_LINE:EAPM_LO_LINE] mem_sel;
  logic [EAPM_HI_LINE:EAPM_LO_LINE] inhibit;

  // Bus decode
  assign idx = i_wb_adr[EAPM_ADR_W-1:2];
  assign wr_go = i_wb_cyc & i_wb_stb & ~o_wb_ack & i_wb_we & i_wb_sel[0];
  assign rd_go = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~i_wb_we;

  // ==========================================================
  // Wishbone ack, one cycle after request, dropped the next
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
    end
  end

  // Read data, unmapped reads return zero
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_dat <= '0;
    end else if (rd_go) begin
      unique case (idx)
        EAPM_IDX_BUS_SEL: begin
          o_wb_dat <= {26'h0, bus_select_reg_q};
        end
        EAPM_IDX_PIN_STAT: begin
          o_wb_dat <= {22'h0, pad_sync_q};
        end
        EAPM_IDX_PULL_A: begin
          o_wb_dat <= {26'h0, pull_inhibit_ctrl_a_q};
        end
        EAPM_IDX_PULL_B: begin
          o_wb_dat <= {28'h0, pull_inhibit_ctrl_b_q};
        end
        default: begin
          o_wb_dat <= '0;
        end
      endcase
    end
  end

  // Mode bits, general I/O after reset
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bus_select_reg_q <= EAPM_BUS_SEL_RST;
    end else if (wr_go && idx == EAPM_IDX_BUS_SEL) begin
      bus_select_reg_q <= i_wb_dat[EAPM_NSHARED-1:0];
    end
  end

  // Pull inhibit A for the shared lines
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pull_inhibit_ctrl_a_q <= EAPM_PULL_A_RST;
    end else if (wr_go && idx == EAPM_IDX_PULL_A) begin
      pull_inhibit_ctrl_a_q <= i_wb_dat[EAPM_NSHARED-1:0];
    end
  end

  // Pull inhibit B for dedicated lines
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pull_inhibit_ctrl_b_q <= EAPM_PULL_B_RST;
    end else if (wr_go && idx == EAPM_IDX_PULL_B) begin
      pull_inhibit_ctrl_b_q <= i_wb_dat[EAPM_PULL_B_W-1:0];
    end
  end

  // ==========================================================
  // Pad input synchroniser
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pad_meta_q <= '0;
      pad_sync_q <= '0;
    end else begin
      pad_meta_q <= i_pad_in;
      pad_sync_q <= pad_meta_q;
    end
  end

  // Shared pin inputs toward general I/O
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_gp_in <= '0;
    end else begin
      o_gp_in <= pad_sync_q[EAPM_NPIN-1:EAPM_PULL_B_W];
    end
  end

  // ==========================================================
  // Memory-side value with NAND latch enables
  always_comb begin
    mem_out = i_mem_addr;
    if (i_nand_active) begin
      mem_out[EAPM_CLE_LINE] = i_nand_cle;
      mem_out[EAPM_ALE_LINE] = i_nand_ale;
    end
  end

  // Per-line select and inhibit vectors
  assign mem_sel = {bus_select_reg_q, {EAPM_PULL_B_W{1'b1}}};
  assign inhibit = {pull_inhibit_ctrl_a_q, pull_inhibit_ctrl_b_q};

  // One cell per pad
  for (genvar g = EAPM_LO_LINE; g <= EAPM_HI_LINE; g++) begin : g_pin
    logic gp_o;
    logic gp_oe_n;
    if (g >= EAPM_SHARED_LO) begin : g_shared
      assign gp_o = i_gp_out[g-EAPM_SHARED_LO];
      assign gp_oe_n = i_gp_oe_n[g-EAPM_SHARED_LO];
    end else begin : g_dedic
      assign gp_o = 1'b0;
      assign gp_oe_n = 1'b1;
    end
    eapm_pin_cell u_cell (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_mem_sel(mem_sel[g]),
      .i_gp_out(gp_o),
      .i_gp_oe_n(gp_oe_n),
      .i_mem_out(mem_out[g]),
      .i_mem_oe_n(i_mem_addr_oe_n),
      .i_pull_inhibit(inhibit[g]),
      .o_pin_out(o_pad_out[g]),
      .o_pin_oe_n(o_pad_oe_n[g]),
      .o_pulldown_en(o_pad_pulldown_en[g])
    );
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  ack_one_cycle_a: assert property (
    (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack)
    else $error("Wishbone ack not a single cycle");

  gp_owns_pin_a: assert property (
    !bus_select_reg_q[5] |=> o_pad_oe_n[20] == $past(i_gp_oe_n[5]))
    else $error("Memory side drove a general I/O pin");

  mem_owns_pin_a: assert property (
    bus_select_reg_q[0] |=> o_pad_out[15] == $past(mem_out[15]))
    else $error("Selected line 15 not on memory side");

  mode_write_a: assert property (
    (wr_go && idx == EAPM_IDX_BUS_SEL) |=>
      bus_select_reg_q == $past(i_wb_dat[5:0]))
    else $error("Bus select write lost");

  mode_steady_a: assert property (
    !(wr_go && idx == EAPM_IDX_BUS_SEL) |=> $stable(bus_select_reg_q))
    else $error("Mode bits changed without a write");

  pull_a_pad_a: assert property (
    (wr_go && idx == EAPM_IDX_PULL_A) |=>
      ##1 o_pad_pulldown_en[20:15] == ~$past(i_wb_dat[5:0], 2))
    else $error("Pull register A not on pads");

  pull_b_pad_a: assert property (
    (wr_go && idx == EAPM_IDX_PULL_B) |=>
      ##1 o_pad_pulldown_en[14:11] == ~$past(i_wb_dat[3:0], 2))
    else $error("Pull register B not on pads");

  pull_reset_a: assert property (
    $rose(i_resetn) |-> o_pad_pulldown_en == '0)
    else $error("Pulldown enabled out of reset");

  cle_drive_a: assert property (
    i_nand_active |=> o_pad_out[12] == $past(i_nand_cle))
    else $error("Line 12 not carrying command latch enable");

  ale_drive_a: assert property (
    i_nand_active |=> o_pad_out[11] == $past(i_nand_ale))
    else $error("Line 11 not carrying address latch enable");

  // Main scenarios
  cov_mode_set_c: cover property (bus_select_reg_q == 6'h3F);
  cov_pull_on_c: cover property (o_pad_pulldown_en != '0);
  cov_nand_c: cover property (i_nand_active && i_nand_cle);
  cov_read_c: cover property (rd_go ##1 o_wb_ack);

endmodule

// ==== pkg/eapm_pkg.sv ====
// Purpose: Constants for the external memory address pin mux.
// Assumes: Registers are 32-bit Wishbone words at four times their index.
// Notes: Pull inhibit bits set mean the internal pulldown is off.
//
// Behaviour
// - Pins of address lines 15 to 20 are shared with general I/O.
// - Each shared pin has its own mode bit in the bus select register.
// - Shared pins come up as general I/O and switch only when software sets the mode bit.
// - Pulldowns of lines 15 to 20 are switched by pull inhibit register A at 1C18h.
// - Pulldowns of lines 11 to 14 are switched by pull inhibit register B at 1C4Dh.
// - Every pulldown of the group is off after reset until software turns it on.
// - During NAND accesses line 12 carries command latch enable.
// - During NAND accesses line 11 carries address latch enable.

package eapm_pkg;

  // ==========================================================
  // Bus and register map
  localparam int EAPM_ADR_W = 16;
  localparam int EAPM_DAT_W = 32;
  localparam logic [13:0] EAPM_IDX_BUS_SEL = 14'h1C00;
  localparam logic [13:0] EAPM_IDX_PIN_STAT = 14'h1C01;
  localparam logic [13:0] EAPM_IDX_PULL_A = 14'h1C18;
  localparam logic [13:0] EAPM_IDX_PULL_B = 14'h1C4D;

  // ==========================================================
  // Pin group layout
  localparam int EAPM_LO_LINE = 11;
  localparam int EAPM_SHARED_LO = 15;
  localparam int EAPM_HI_LINE = 20;
  localparam int EAPM_NPIN = EAPM_HI_LINE - EAPM_LO_LINE + 1;
  localparam int EAPM_NSHARED = EAPM_HI_LINE - EAPM_SHARED_LO + 1;
  localparam int EAPM_CLE_LINE = 12;
  localparam int EAPM_ALE_LINE = 11;
  // Pull register B bit 0 is line 11, pull register A bit 0 is line 15
  localparam int EAPM_PULL_B_W = EAPM_SHARED_LO - EAPM_LO_LINE;

  // ==========================================================
  // Reset values
  localparam logic [5:0] EAPM_BUS_SEL_RST = 6'h00;
  localparam logic [5:0] EAPM_PULL_A_RST = 6'h3F;
  localparam logic [3:0] EAPM_PULL_B_RST = 4'hF;

  // ==========================================================
  // Timing
  localparam int EAPM_CLK_PERIOD_NS = 25;
  localparam int EAPM_SYNC_STAGES = 2;

endpackage

// ==== sim/eapm_mem_model.sv ====
// Purpose: Far side model, memory address pins on the board.
// Assumes: The memory only receives on these lines.
// Notes: Released pins without pulldown toggle every cycle.
`timescale 1ns/100ps
module eapm_mem_model (
  input wire logic i_ref_clk,
  input wire logic [9:0] i_pad_out,
  input wire logic [9:0] i_pad_oe_n,
  input wire logic [9:0] i_pad_pulldown_en,
  output logic [9:0] o_pad_level,
  output logic [22:13] o_x8_addr,
  output logic [20:11] o_x16_addr
);
  // ==========================================================
  // Floating pattern, never a settled unknown
  logic [9:0] float_q = 10'h155;
  always @(posedge i_ref_clk) begin
    float_q <= ~float_q;
  end
  // Wire level per line, bit 0 is line 11
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (!i_pad_oe_n[i]) o_pad_level[i] = i_pad_out[i];
      else if (i_pad_pulldown_en[i]) o_pad_level[i] = 1'h0;
      else o_pad_level[i] = float_q[i];
    end
  end
  // Board wiring of the upper lines into each memory width
  assign o_x8_addr = o_pad_level;
  assign o_x16_addr = o_pad_level;
endmodule

// ==== sim/tb.sv ====
// Purpose: Self-checking bench for the address pin mux.
// Assumes: Ack comes one cycle after the taking edge.
// Notes: Rows cover pin steering, hand tests cover registers and reset.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  n_errors++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb import eapm_pkg::*;;
  typedef struct packed {
    logic [5:0] sel;
    logic [9:0] mem;
    logic [5:0] gpo;
    logic [5:0] gpoe;
    logic [2:0] ncl;
    logic [9:0] eout;
    logic [9:0] eoe;
  } eapm_row_s;
  // ==========================================================
  // Signals
  logic clk = 1'h0, resetn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [15:0] adr = 16'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dw = 32'h0, dr, q;
  logic ack, moe_n = 1'h0;
  logic [2:0] ncl = 3'h0;
  logic [9:0] mem = 10'h0, pin, pout, poe_n, ppd;
  logic [9:0] x8a, x16a;
  logic [5:0] gpo = 6'h0, gpoe = 6'h3F, gpin;
  int n_errors = 0, checks = 0;
  eapm_row_s rows [5] = '{
    '{6'h00, 10'h3FF, 6'h15, 6'h00, 3'h0, 10'h15F, 10'h000},
    '{6'h3F, 10'h2A5, 6'h3F, 6'h00, 3'h0, 10'h2A5, 10'h000},
    '{6'h05, 10'h3F0, 6'h00, 6'h3F, 3'h0, 10'h050, 10'h3A0},
    '{6'h00, 10'h000, 6'h00, 6'h3F, 3'h6, 10'h002, 10'h3F0},
    '{6'h00, 10'h002, 6'h00, 6'h3F, 3'h5, 10'h001, 10'h3F0}};
  eapm_top eapm_top_inst (.i_ref_clk(clk), .i_resetn(resetn),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(dw), .o_wb_dat(dr), .o_wb_ack(ack),
    .i_mem_addr(mem), .i_mem_addr_oe_n(moe_n), .i_nand_active(ncl[2]),
    .i_nand_cle(ncl[1]), .i_nand_ale(ncl[0]), .i_gp_out(gpo),
    .i_gp_oe_n(gpoe), .o_gp_in(gpin), .i_pad_in(pin), .o_pad_out(pout),
    .o_pad_oe_n(poe_n), .o_pad_pulldown_en(ppd));
  eapm_mem_model eapm_mem_model_inst (.i_ref_clk(clk), .i_pad_out(pout),
    .i_pad_oe_n(poe_n), .i_pad_pulldown_en(ppd), .o_pad_level(pin),
    .o_x8_addr(x8a), .o_x16_addr(x16a));
  // ==========================================================
  // Clock and tasks
  initial begin
    forever #12.5 clk = ~clk;
  end
  // One classic Wishbone cycle, result left in q
  task automatic wb(input logic w, input logic [15:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    q = dr;
    cyc <= 1'h0;
    stb <= 1'h0;
    // Ack must be gone one cycle after it was taken
    @(posedge clk);
    `CHK("wb_ack_drop", 1'h0, ack)
  endtask
  // Let synchronisers and pad registers settle
  task automatic settle;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask
  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    results;
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    `CHK("rst_oe_n", 10'h3FF, poe_n)
    `CHK("rst_pd", 10'h000, ppd)
    @(posedge clk);
    resetn <= 1'h1;
    wb(1'h0, 16'h7000, 32'h0, 4'hF);
    `CHK("bus_sel", 32'h0, q)
    wb(1'h0, 16'h7060, 32'h0, 4'hF);
    `CHK("pull_a", 32'h3F, q)
    wb(1'h0, 16'h7134, 32'h0, 4'hF);
    `CHK("pull_b", 32'hF, q)
    wb(1'h1, 16'h7000, 32'h3F, 4'h0);
    wb(1'h1, 16'h7FF0, 32'h3F, 4'hF);
    wb(1'h0, 16'h7FF0, 32'h0, 4'hF);
    `CHK("unmapped", 32'h0, q)
    wb(1'h0, 16'h7000, 32'h0, 4'hF);
    `CHK("bus_sel_kept", 32'h0, q)
    $display("test registers done");
    foreach (rows[i]) begin
      wb(1'h1, 16'h7000, {26'h0, rows[i].sel}, 4'hF);
      mem <= rows[i].mem;
      gpo <= rows[i].gpo;
      gpoe <= rows[i].gpoe;
      ncl <= rows[i].ncl;
      settle;
      `CHK("pad_out", rows[i].eout, pout)
      `CHK("pad_oe_n", rows[i].eoe, poe_n)
    end
    $display("test rows done");
    wb(1'h1, 16'h7060, 32'h0, 4'hF);
    wb(1'h1, 16'h7134, 32'h0, 4'hF);
    settle;
    `CHK("pd_all", 10'h3FF, ppd)
    wb(1'h1, 16'h7060, 32'h2A, 4'hF);
    wb(1'h1, 16'h7134, 32'h5, 4'hF);
    settle;
    `CHK("pd_mix", 10'h15A, ppd)
    $display("test pulldown done");
    wb(1'h1, 16'h7000, 32'h3F, 4'hF);
    mem <= 10'h2A5;
    ncl <= 3'h0;
    settle;
    `CHK("gp_in", 6'h2A, gpin)
    `CHK("x8_addr", 10'h2A5, x8a)
    `CHK("x16_addr", 10'h2A5, x16a)
    wb(1'h0, 16'h7004, 32'h0, 4'hF);
    `CHK("pin_stat", 32'h2A5, q)
    // Memory releases its lines, pulldowns hold them low
    wb(1'h1, 16'h7060, 32'h0, 4'hF);
    wb(1'h1, 16'h7134, 32'h0, 4'hF);
    moe_n <= 1'h1;
    settle;
    `CHK("rel_oe_n", 10'h3FF, poe_n)
    wb(1'h0, 16'h7004, 32'h0, 4'hF);
    `CHK("rel_stat", 32'h0, q)
    $display("test status done");
    moe_n <= 1'h0;
    gpoe <= 6'h3F;
    resetn <= 1'h0;
    @(negedge clk);
    `CHK("mid_pd", 10'h000, ppd)
    @(posedge clk);
    resetn <= 1'h1;
    settle;
    `CHK("gp_back", 10'h3F0, poe_n)
    $display("test mid reset done");
    results;
  end
endmodule
